// >>> verilog/sup_counter.sv
// supervision counter top: prescaler, 16-bit count, window and time-out
// assumes i_service is a one-cycle strobe from same-clock logic
// a failure is final until i_rstn; a later service cannot undo it
`timescale 1ns/1ps
module sup_counter
   import sup_pkg::*;
(
   input  wire logic       i_clock,
   input  wire logic       i_rstn,
   input  wire sup_cfg_t   i_cfg,
   input  wire logic       i_service,
   input  wire logic       i_debug,
   output logic            o_nmi,
   output logic            o_prewarn,
   output logic            o_sys_reset,
   output logic [15:0]     o_count
);
   // ****************************************************************
   // input synchroniser for debug pin
   // ****************************************************************
   // debug comes from a pin: two flops before anything reads it
   logic       dbg_s1_r;
   logic       dbg_r;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         dbg_s1_r <= 1'b0;
         dbg_r    <= 1'b0;
      end else begin
         dbg_s1_r <= i_debug;
         dbg_r    <= dbg_s1_r;
      end
   end

   // ****************************************************************
   // prescaler
   // ****************************************************************
   logic [6:0]  pre_r;
   logic        tick;
   logic        running;
   sup_state_t  state_r;
   logic [7:0]  low;
   logic [7:0]  high;
   logic        low_carry;
   logic        high_carry;
   logic        bad_service;
   logic        timeout;
   logic [7:0]  warn_r;

   // the count runs only before a failure and outside debug
   assign running = (state_r == SUP_RUN) && !dbg_r;
   assign tick    = running && ((pre_r & (i_cfg.slow_rate ?
                    SUP_DIV_SLOW : SUP_DIV_FAST)) == 7'h00);

   // prescaler restarts on service; stops in debug so time does not build up
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         pre_r <= 7'h00;
      end else if (i_service) begin
         pre_r <= 7'h01;
      end else if (running) begin
         pre_r <= pre_r + 7'h01;
      end
   end

   // ****************************************************************
   // chained halves
   // ****************************************************************
   // index 0 is the lower byte, index 1 the upper byte
   logic [7:0] half_value [2];
   logic       half_inc   [2];
   logic [7:0] half_count [2];
   logic       half_carry [2];

   // lower byte clears, upper byte takes the reload on service
   assign half_value[0] = 8'h00;
   assign half_value[1] = i_cfg.reload;
   // only a lower wrap moves the upper byte
   assign half_inc[0]   = tick;
   assign half_inc[1]   = half_carry[0];

   // one generic half, chained through the arrays above
   for (genvar gi = 0; gi < 2; gi++) begin : g_half
      sup_byte sup_byte_inst (
         .i_clock (i_clock),
         .i_rstn  (i_rstn),
         .i_load  (i_service),
         .i_value (half_value[gi]),
         .i_inc   (half_inc[gi]),
         .o_count (half_count[gi]),
         .o_carry (half_carry[gi])
      );
   end

   assign low        = half_count[0];
   assign high       = half_count[1];
   assign low_carry  = half_carry[0];
   assign high_carry = half_carry[1];

   assign o_count     = {high, low};
   // early service is as bad as a late one
   // window 8'h00 can never be undercut, so it turns the check off
   assign bad_service = i_service && running && (high < i_cfg.window);
   assign timeout     = high_carry || bad_service;

   // ****************************************************************
   // failure sequence: interrupt and prewarning, then reset
   // ****************************************************************
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r <= SUP_RUN;
         warn_r  <= 8'h00;
      end else begin
         // a failure is final; only i_rstn leaves SUP_RESET
         unique case (state_r)
            SUP_RUN: begin
               if (timeout) begin
                  state_r <= SUP_WARN;
                  warn_r  <= SUP_PREWARN_CYC;
               end
            end
            SUP_WARN: begin
               // count the prewarning down, reset after its last cycle
               if (warn_r == 8'h01) begin
                  state_r <= SUP_RESET;
               end
               warn_r <= warn_r - 8'h01;
            end
            SUP_RESET: begin
               state_r <= SUP_RESET;  // held until chip reset
            end
            default: begin
               state_r <= SUP_RESET;
            end
         endcase
      end
   end

   // registered outputs
   // the interrupt fires on the failure edge, prewarn one edge later
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_nmi       <= 1'b0;
         o_prewarn   <= 1'b0;
         o_sys_reset <= 1'b0;
      end else begin
         o_nmi       <= (state_r == SUP_RUN) && timeout;
         o_prewarn   <= (state_r == SUP_WARN);
         o_sys_reset <= (state_r == SUP_RESET);
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);

   // prewarning length seen from outside, checked when the level drops
   logic [7:0] pw_len_r;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         pw_len_r <= 8'h00;
      end else if (o_prewarn) begin
         pw_len_r <= pw_len_r + 8'h01;
      end
   end

   // service and chain behaviour
   service_load_a: assert property (i_service && state_r == SUP_RUN
      |=> o_count == {$past(i_cfg.reload), 8'h00})
      else $error("service did not preload count");
   low_clear_a: assert property (i_service |=> low == 8'h00)
      else $error("low byte not cleared");
   debug_hold_a: assert property (dbg_r && !i_service
      |=> $stable(o_count))
      else $error("count moved in debug");
   chain_carry_a: assert property (low_carry |=> high ==
      $past(high) + 8'h01)
      else $error("upper half missed carry");
   // the reset cycle leaves a stale tick behind, so skip the first edge
   fast_rate_a: assert property (running && !i_cfg.slow_rate
      && !i_service && $past(i_rstn) && $past(tick) |-> !tick)
      else $error("fast rate ticked twice running");

   // failure sequence
   nmi_pulse_a: assert property (timeout && state_r == SUP_RUN
      |=> o_nmi ##1 o_prewarn)
      else $error("nmi and prewarn not raised");
   reset_follow_a: assert property ($rose(o_prewarn)
      |-> ##[1:40] o_sys_reset)
      else $error("system reset did not follow");
   window_fail_a: assert property (bad_service
      |=> state_r == SUP_WARN)
      else $error("early service not treated as failure");
   overflow_fail_a: assert property (high_carry && state_r == SUP_RUN
      |=> state_r == SUP_WARN)
      else $error("overflow not treated as time-out");
   // the interrupt is a single pulse per failure
   nmi_single_a: assert property (o_nmi |=> !o_nmi)
      else $error("nmi longer than one cycle");
   // prewarning must follow the interrupt directly
   warn_order_a: assert property ($rose(o_prewarn) |-> $past(o_nmi))
      else $error("prewarn without nmi");
   prewarn_len_a: assert property ($fell(o_prewarn)
      |-> pw_len_r == SUP_PREWARN_CYC)
      else $error("prewarn length wrong");
   // only a chip reset may clear the system reset request
   reset_sticky_a: assert property (o_sys_reset |=> o_sys_reset)
      else $error("system reset dropped");
   // a service after a failure must not restart the count
   fail_final_a: assert property (state_r != SUP_RUN && i_service
      |=> state_r != SUP_RUN)
      else $error("service left the failure state");
   // a service during debug is never a window failure
   debug_svc_a: assert property (i_service && dbg_r |=> !o_nmi)
      else $error("service in debug raised nmi");

   // main scenarios the bench must reach
   svc_c:    cover property (i_service && !bad_service);
   tmo_c:    cover property (high_carry);
   early_c:  cover property (bad_service);
   rst_c:    cover property (o_sys_reset);
   dbg_c:    cover property (i_service && dbg_r);
endmodule : sup_counter

// >>> verilog/sup_pkg.sv
// package for the supervision counter: constants and carrier types
// assumes one 125 MHz clock; service and config come from same-clock logic
// ****************************************************************
// How it works
// - in debug mode the counter is suspended and stops counting.
// - the count is 16 bits and advances at the clock divided by 2 or by 128.
// - two chained 8-bit halves form the count, lower overflow advances upper.
// - a service access loads the upper byte with the programmed reload value.
// - a service access clears the lower byte.
// - a time-out raises an interrupt and a prewarning, then a system reset.
// ****************************************************************
package sup_pkg;
   localparam int          SUP_HALF_W     = 8;
   localparam logic [6:0]  SUP_DIV_SLOW   = 7'h7f;  // divide by 128
   localparam logic [6:0]  SUP_DIV_FAST   = 7'h01;  // divide by 2
   localparam logic [7:0]  SUP_RST_RELOAD = 8'h00;
   localparam logic [7:0]  SUP_RST_WINDOW = 8'h00;
   // prewarning time before the system reset, in ns and in cycles
   localparam int          SUP_PREWARN_NS = 256;
   localparam int          SUP_CLK_NS     = 8;
   localparam logic [7:0]  SUP_PREWARN_CYC =
      8'((SUP_PREWARN_NS + SUP_CLK_NS - 1) / SUP_CLK_NS);

   typedef struct packed {
      logic       slow_rate;   // 1: clock/128, 0: clock/2
      logic [7:0] reload;      // upper byte preset on service
      logic [7:0] window;      // service forbidden while upper byte below
   } sup_cfg_t;

   typedef enum logic [1:0] {
      SUP_RUN   = 2'b00,
      SUP_WARN  = 2'b01,
      SUP_RESET = 2'b11
   } sup_state_t;
endpackage : sup_pkg

// >>> verilog/sup_byte.sv
// one 8-bit counting half of the supervision counter
// assumes carry-in and load arrive on the same clock
`timescale 1ns/1ps
module sup_byte
   import sup_pkg::*;
(
   input  wire logic       i_clock,
   input  wire logic       i_rstn,
   input  wire logic       i_load,
   input  wire logic [7:0] i_value,
   input  wire logic       i_inc,
   output logic [7:0]      o_count,
   output logic            o_carry
);
   // load wins over increment so a service never loses to a tick
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_count <= 8'h00;
      end else if (i_load) begin
         o_count <= i_value;
      end else if (i_inc) begin
         o_count <= o_count + 8'h01;
      end
   end

   // carry seen when this half wraps on the current tick
   assign o_carry = i_inc && !i_load && (o_count == 8'hff);
endmodule : sup_byte

// >>> verification/sup_counter_tb_top.sv
// self-checking bench for the supervision counter top
// assumes sup_pkg compiled first; inputs driven on the falling edge
`timescale 1ns/1ps
module sup_counter_tb_top;
   import sup_pkg::*;
   logic        i_clock = 1'b0;
   logic        i_rstn = 1'b0;
   logic        i_service = 1'b0;
   logic        i_debug = 1'b0;
   sup_cfg_t    i_cfg = '0;
   logic        o_nmi;
   logic        o_prewarn;
   logic        o_sys_reset;
   logic [15:0] o_count;
   logic [15:0] c0;
   int          error_cnt = 0;
   int          check_count = 0;
   // 125 MHz clock
   always #4 i_clock = ~i_clock;
   sup_counter sup_counter_inst (.i_clock(i_clock), .i_rstn(i_rstn),
      .i_cfg(i_cfg), .i_service(i_service), .i_debug(i_debug),
      .o_nmi(o_nmi), .o_prewarn(o_prewarn),
      .o_sys_reset(o_sys_reset), .o_count(o_count));
   // ****************************************************************
   // shared helpers
   // ****************************************************************
   task automatic chk(input string nm, input logic [15:0] e, g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up
   // reset is the only way out of a latched failure
   task automatic rst();
      i_rstn = 1'b0;
      repeat (10) @(negedge i_clock);
      i_rstn = 1'b1;
      @(negedge i_clock);
   endtask : rst
   task automatic svc();
      i_service = 1'b1;
      @(negedge i_clock);
      i_service = 1'b0;
   endtask : svc
   // bounded wait; running out of cycles ends the run
   task automatic wait_nmi(input int lim);
      int n;
      n = 0;
      while (o_nmi !== 1'b1 && n < lim) begin
         @(negedge i_clock);
         n++;
      end
      chk("nmi", 16'h1, {15'h0, o_nmi});
      if (o_nmi !== 1'b1) wrap_up();
   endtask : wait_nmi
   // ****************************************************************
   // scenarios
   // ****************************************************************
   // back-to-back services at slow rate
   task automatic t_load();
      i_cfg = '{1'b1, 8'h5a, 8'h00};
      i_service = 1'b1;
      @(negedge i_clock);
      i_cfg.reload = 8'ha5;
      @(negedge i_clock);
      i_service = 1'b0;
      chk("count", 16'ha500, o_count);
   endtask : t_load
   // count advance over a whole number of prescaler periods
   task automatic t_rate(input logic s, input int cyc, input int d);
      i_cfg = '{s, 8'h00, 8'h00};
      svc();
      c0 = o_count;
      repeat (cyc) @(negedge i_clock);
      chk("advance", 16'(d), o_count - c0);
   endtask : t_rate
   // two edges of synchroniser latency before freeze
   task automatic t_debug();
      i_debug = 1'b1;
      repeat (4) @(negedge i_clock);
      c0 = o_count;
      repeat (300) @(negedge i_clock);
      chk("frozen", c0, o_count);
      i_debug = 1'b0;
   endtask : t_debug
   task automatic t_timeout();
      int n;
      i_cfg = '{1'b0, 8'hff, 8'h00};
      svc();
      wait_nmi(600);
      @(negedge i_clock);
      chk("nmi pulse", 16'h0, {15'h0, o_nmi});
      n = 0;
      while (o_prewarn === 1'b1 && n < 100) begin
         @(negedge i_clock);
         n++;
      end
      chk("prewarn len", 16'(SUP_PREWARN_CYC), 16'(n));
      svc();
      chk("sys reset", 16'h1, {15'h0, o_sys_reset});
   endtask : t_timeout
   // legal service above boundary, then early one below it
   task automatic t_window();
      i_cfg = '{1'b1, 8'h90, 8'h00};
      svc();
      i_cfg = '{1'b1, 8'h00, 8'h80};
      svc();
      chk("no nmi", 16'h0, {15'h0, o_nmi});
      repeat (3) @(negedge i_clock);
      chk("no fail", 16'h0, {15'h0, o_prewarn});
      svc();
      wait_nmi(3);
   endtask : t_window
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      rst();
      t_load();
      t_rate(1'b0, 600, 300);
      t_rate(1'b1, 1280, 10);
      t_debug();
      t_timeout();
      rst();
      t_window();
      wrap_up();
   end
endmodule : sup_counter_tb_top
